/* File: rtl/pmc_pkg.sv */
// Package for the power mode controller: register map, fields, timing
package pmc_pkg;
    // Clock rate in kHz
    localparam int CLK_KHZ = 20000;
    // Wake-up times in ns
    localparam int WAKE_IDLE_NS = 14000;
    localparam int WAKE_STBY_NS = 151000;
    localparam int WAKE_COLD_NS = 1015000;
    // All three times round down to whole cycles, with no one-cycle minimum
    localparam int WAKE_IDLE_CYC = (WAKE_IDLE_NS * (CLK_KHZ / 1000)) / 1000;
    localparam int WAKE_STBY_CYC = (WAKE_STBY_NS * (CLK_KHZ / 1000)) / 1000;
    localparam int WAKE_COLD_CYC = (WAKE_COLD_NS * (CLK_KHZ / 1000)) / 1000;
    // Register byte offsets
    localparam logic [7:0] OFF_MODE = 8'h00;
    localparam logic [7:0] OFF_CLKSEL = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_RSTCAUSE = 8'h0C;
    localparam logic [7:0] OFF_IRQSTAT = 8'h10;
    localparam logic [7:0] OFF_IRQMASK = 8'h14;
    localparam logic [7:0] OFF_WAKEPIN = 8'h18;
    // Reset values
    localparam logic [3:0] CLKSEL_RST = 4'h0;
    localparam logic [3:0] IRQMASK_RST = 4'h0;
    // Clock select field positions
    localparam int CS_FAST_RC = 0;
    localparam int CS_SLOW_XTAL = 1;
    localparam int CS_CLKOUT = 2;
    // Reset cause codes
    localparam logic [1:0] CAUSE_POR = 2'h0;
    localparam logic [1:0] CAUSE_PIN = 2'h1;
    localparam logic [1:0] CAUSE_WAKEPIN = 2'h2;
    // Event bits
    localparam int EV_WAKE = 0;
    localparam int EV_SLEEP = 1;
    localparam int EV_BOD = 2;
    localparam int EV_RESET = 3;
    // Mode request codes
    localparam logic [1:0] REQ_IDLE = 2'h1;
    localparam logic [1:0] REQ_STBY = 2'h2;
    localparam logic [1:0] REQ_SHUT = 2'h3;

    // Power states
    typedef enum logic [3:0] {
        ST_HELD = 4'b0000,
        ST_BOOT = 4'b0001,
        ST_ACTIVE = 4'b0010,
        ST_GATE = 4'b0011,
        ST_LATCH = 4'b0100,
        ST_PWRDN = 4'b0101,
        ST_IDLE = 4'b0110,
        ST_STBY = 4'b0111,
        ST_SHUT = 4'b1000,
        ST_WAKE = 4'b1001
    } pstate_e;

    // Clock gate bundle
    typedef struct packed {
        logic cpu;
        logic mem;
        logic periph;
        logic radio;
    } gates_s;

    // Wake-up sources
    typedef struct packed {
        logic irq;
        logic rtc;
        logic sensor;
    } wake_s;
endpackage

/* File: rtl/power_mode_controller.sv */
// Power mode, wake-up, I/O latch and clock source controller
`timescale 1ns/1ps
// Function
// - Active mode: CPU runs, any fast clock
// - Idle: peripheral clocks on, CPU/memory off
// - Any interrupt wakes idle to active
// - Standby wakes on pin, RTC, sensor only
// - Standby wake resumes; retention kept
// - Standby entry latches all I/O pins
// - Shutdown powers all off; I/O held
// - Shutdown wake pin change acts as reset
// - Reset cause register: wake pin, pin, POR
// - Shutdown keeps latched I/O state, wake pin enables and reset cause
// - Wake times 14, 151, 1015 microseconds
// - Reset pin always wakes; edges not held
// - Brown-out on, duty-cycled, off; POR on except while held in reset
// - Crystal doubled to 48 MHz fast clock
// - Slow RC used without slow crystal
// - Slow clock may drive a GPIO
// - Fast RC may clock the processor
module power_mode_controller #(
    parameter int NPIO = 8,
    parameter int WAKE_COLD = pmc_pkg::WAKE_COLD_CYC,
    parameter int BOD_PERIOD = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Wake sources and pins
    input wire logic irqEvent,
    input wire logic rtcEvent,
    input wire logic sensorEvent,
    input wire logic resetPin_n,
    input wire logic [NPIO-1:0] pinIn,
    input wire logic slowClkIn,
    // Pin drive from the I/O controller
    input wire logic [NPIO-1:0] pioOut,
    // Held pin levels and clock-out
    output logic [NPIO-1:0] pinOut,
    output logic pioLatched,
    output logic clkOutPin,
    // Clock gates and power
    output pmc_pkg::gates_s gates,
    output logic alwaysOnPower,
    output logic sensorPower,
    output logic cpuReset,
    output logic bodEnable,
    output logic porEnable,
    output logic fastRcSel,
    output logic slowRcSel,
    output logic pllDouble,
    // Interrupt
    output logic irq
);
    // Synchronised pin inputs (first stage read only by second)
    logic [NPIO+5:0] syncA, syncB;
    logic [NPIO-1:0] pinPrev;
    logic rstPinS, irqS, rtcS, sensS, slowS;
    // Control and state
    pmc_pkg::pstate_e state, next_state;
    logic [19:0] cnt;
    logic [1:0] modeReq, cause;
    logic [3:0] clkSel, irqStat, irqMask;
    logic [NPIO-1:0] wakePinEn;
    logic [7:0] bodCnt;
    // Bus handshake state
    logic awHeld, wHeld;
    logic [7:0] awAddr;
    logic [31:0] wData;

    always_ff @(posedge clk) begin
        syncA <= {slowClkIn, sensorEvent, rtcEvent, irqEvent, resetPin_n,
                  1'b0, pinIn};
        syncB <= syncA;
    end
    assign rstPinS = syncB[NPIO+1];
    assign irqS = syncB[NPIO+2];
    assign rtcS = syncB[NPIO+3];
    assign sensS = syncB[NPIO+4];
    assign slowS = syncB[NPIO+5];

    // Decoded wake conditions
    wire pinChange = |((syncB[NPIO-1:0] ^ pinPrev) & wakePinEn);
    wire pinHeld = ~rstPinS;
    wire doWrite = awHeld && wHeld && !s_axi_bvalid;
    wire doRead = s_axi_arvalid && !s_axi_rvalid;
    wire wrMode = doWrite && awAddr == pmc_pkg::OFF_MODE && wData[1:0] != 0;
    wire cntDone = cnt == 20'h0_0000;
    // Standby wakes only on pin, RTC or sensor events
    wire stbyWake = pinChange | rtcS | sensS;
    wire coldWake = pinChange;

    // Power state machine
    always_comb begin
        next_state = state;
        unique case (state)
            pmc_pkg::ST_HELD:
                if (!pinHeld) next_state = pmc_pkg::ST_BOOT;
            pmc_pkg::ST_BOOT:
                if (cntDone) next_state = pmc_pkg::ST_ACTIVE;
            pmc_pkg::ST_ACTIVE:
                if (modeReq != 2'h0) next_state = pmc_pkg::ST_GATE;
            pmc_pkg::ST_GATE:
                next_state = modeReq == pmc_pkg::REQ_IDLE ?
                    pmc_pkg::ST_IDLE : pmc_pkg::ST_LATCH;
            pmc_pkg::ST_LATCH:
                next_state = pmc_pkg::ST_PWRDN;
            pmc_pkg::ST_PWRDN:
                next_state = modeReq == pmc_pkg::REQ_SHUT ?
                    pmc_pkg::ST_SHUT : pmc_pkg::ST_STBY;
            pmc_pkg::ST_IDLE:
                if (irqS) next_state = pmc_pkg::ST_WAKE;
            pmc_pkg::ST_STBY:
                if (stbyWake) next_state = pmc_pkg::ST_WAKE;
            pmc_pkg::ST_SHUT:
                if (coldWake) next_state = pmc_pkg::ST_BOOT;
            pmc_pkg::ST_WAKE:
                if (cntDone) next_state = pmc_pkg::ST_ACTIVE;
            default:
                next_state = pmc_pkg::ST_HELD;
        endcase
        // Reset pin wins in every state
        if (pinHeld) next_state = pmc_pkg::ST_HELD;
    end

    // State, wake timer and reset cause
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state <= pmc_pkg::ST_HELD;
            cnt <= 20'h0_0000;
            cause <= pmc_pkg::CAUSE_POR;
            pinPrev <= '0;
        end else begin
            state <= next_state;
            pinPrev <= syncB[NPIO-1:0];
            // Load the wake time for the mode being left
            if (next_state == pmc_pkg::ST_BOOT && state != pmc_pkg::ST_BOOT)
                cnt <= 20'(WAKE_COLD - 1);
            else if (next_state == pmc_pkg::ST_WAKE &&
                     state == pmc_pkg::ST_IDLE)
                cnt <= 20'(pmc_pkg::WAKE_IDLE_CYC - 1);
            else if (next_state == pmc_pkg::ST_WAKE &&
                     state == pmc_pkg::ST_STBY)
                cnt <= 20'(pmc_pkg::WAKE_STBY_CYC - 1);
            else if (!cntDone)
                cnt <= cnt - 20'h0_0001;
            // Cause of the cold boot
            if (state == pmc_pkg::ST_SHUT && next_state == pmc_pkg::ST_BOOT)
                cause <= pmc_pkg::CAUSE_WAKEPIN;
            else if (next_state == pmc_pkg::ST_HELD &&
                     state != pmc_pkg::ST_HELD)
                cause <= pmc_pkg::CAUSE_PIN;
        end
    end

    // Registers lost in shutdown and on reset, I/O latch kept in shutdown
    wire coldReset = !nrst || state == pmc_pkg::ST_SHUT ||
                     state == pmc_pkg::ST_HELD;
    wire [3:0] events = {state == pmc_pkg::ST_BOOT && cntDone,
                         bodEnable && bodCnt == 8'h00,
                         next_state == pmc_pkg::ST_GATE,
                         state == pmc_pkg::ST_WAKE && cntDone};
    wire readStat = doRead && s_axi_araddr == pmc_pkg::OFF_IRQSTAT;

    always_ff @(posedge clk) begin
        if (coldReset) begin
            modeReq <= 2'h0;
            clkSel <= pmc_pkg::CLKSEL_RST;
            irqMask <= pmc_pkg::IRQMASK_RST;
            irqStat <= 4'h0;
        end else begin
            if (wrMode && state == pmc_pkg::ST_ACTIVE)
                modeReq <= wData[1:0];
            else if (state == pmc_pkg::ST_WAKE)
                modeReq <= 2'h0;
            if (doWrite && awAddr == pmc_pkg::OFF_CLKSEL)
                clkSel <= wData[3:0];
            if (doWrite && awAddr == pmc_pkg::OFF_IRQMASK)
                irqMask <= wData[3:0];
            // Set wins over the clear-on-read
            irqStat <= (readStat ? 4'h0 : irqStat) | events;
        end
    end

    // Wake pin enables ride through shutdown with the latched I/O;
    // clearing them there would leave only the reset pin to exit shutdown
    always_ff @(posedge clk) begin
        if (!nrst || state == pmc_pkg::ST_HELD)
            wakePinEn <= '0;
        else if (doWrite && awAddr == pmc_pkg::OFF_WAKEPIN)
            wakePinEn <= wData[NPIO-1:0];
    end

    // Brown-out sampling: duty cycled in standby
    always_ff @(posedge clk) begin
        if (!nrst) bodCnt <= 8'h00;
        else bodCnt <= bodCnt == 8'(BOD_PERIOD - 1) ? 8'h00 : bodCnt + 8'h01;
    end

    // Outputs per state, all registered
    always_ff @(posedge clk) begin
        if (!nrst) begin
            gates <= '0;
            alwaysOnPower <= 1'b1;
            sensorPower <= 1'b1;
            cpuReset <= 1'b1;
            bodEnable <= 1'b0;
            porEnable <= 1'b1;
            pioLatched <= 1'b0;
            pinOut <= '0;
            fastRcSel <= 1'b0;
            slowRcSel <= 1'b1;
            pllDouble <= 1'b1;
            clkOutPin <= 1'b0;
            irq <= 1'b0;
        end else begin
            // Active: all; idle: peripherals and radio only
            gates.cpu <= next_state == pmc_pkg::ST_ACTIVE;
            gates.mem <= next_state == pmc_pkg::ST_ACTIVE;
            gates.periph <= next_state == pmc_pkg::ST_ACTIVE ||
                            next_state == pmc_pkg::ST_IDLE;
            gates.radio <= next_state == pmc_pkg::ST_ACTIVE ||
                           next_state == pmc_pkg::ST_IDLE;
            alwaysOnPower <= next_state != pmc_pkg::ST_SHUT &&
                             next_state != pmc_pkg::ST_HELD;
            sensorPower <= next_state != pmc_pkg::ST_SHUT &&
                           next_state != pmc_pkg::ST_HELD;
            cpuReset <= next_state == pmc_pkg::ST_HELD ||
                        next_state == pmc_pkg::ST_BOOT ||
                        next_state == pmc_pkg::ST_SHUT;
            // Brown-out continuous awake, strobed in standby
            bodEnable <= next_state == pmc_pkg::ST_ACTIVE ||
                         next_state == pmc_pkg::ST_IDLE ||
                         (next_state == pmc_pkg::ST_STBY &&
                          bodCnt == 8'h00);
            porEnable <= next_state != pmc_pkg::ST_HELD;
            // Latch I/O from latch step until back in active or held
            if (next_state == pmc_pkg::ST_LATCH)
                pinOut <= pioOut;
            else if (!pioLatched)
                pinOut <= pioOut;
            pioLatched <= next_state == pmc_pkg::ST_LATCH ||
                          (pioLatched && next_state != pmc_pkg::ST_ACTIVE &&
                           next_state != pmc_pkg::ST_HELD);
            fastRcSel <= clkSel[pmc_pkg::CS_FAST_RC];
            slowRcSel <= !clkSel[pmc_pkg::CS_SLOW_XTAL];
            pllDouble <= !clkSel[pmc_pkg::CS_FAST_RC];
            clkOutPin <= clkSel[pmc_pkg::CS_CLKOUT] & slowS;
            irq <= |(irqStat & irqMask);
        end
    end

    // AXI4-Lite write channel: address and data in either order
    // Ready flags are registered copies of the next handshake state, so
    // they drop right after a taken beat and never glitch on the pins
    wire awTake = s_axi_awvalid && s_axi_awready;
    wire wTake = s_axi_wvalid && s_axi_wready;
    wire next_awHeld = !doWrite && (awHeld || awTake);
    wire next_wHeld = !doWrite && (wHeld || wTake);
    wire next_bvalid = doWrite || (s_axi_bvalid && !s_axi_bready);
    always_ff @(posedge clk) begin
        if (!nrst) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddr <= 8'h00;
            wData <= 32'h0000_0000;
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end else begin
            // Capture each beat as it is taken
            if (awTake)
                awAddr <= s_axi_awaddr;
            if (wTake)
                wData <= s_axi_wdata;
            awHeld <= next_awHeld;
            wHeld <= next_wHeld;
            // Response stands until the master takes it
            s_axi_bvalid <= next_bvalid;
            s_axi_awready <= !next_awHeld && !next_bvalid;
            s_axi_wready <= !next_wHeld && !next_bvalid;
        end
    end
    // Writes always complete; unused offsets are simply ignored
    assign s_axi_bresp = 2'h0;

    // Read decode
    wire [31:0] rdMux =
        s_axi_araddr == pmc_pkg::OFF_MODE ? {30'h0, modeReq} :
        s_axi_araddr == pmc_pkg::OFF_CLKSEL ? {28'h0, clkSel} :
        s_axi_araddr == pmc_pkg::OFF_STATUS ? {28'h0, state} :
        s_axi_araddr == pmc_pkg::OFF_RSTCAUSE ? {30'h0, cause} :
        s_axi_araddr == pmc_pkg::OFF_IRQSTAT ? {28'h0, irqStat} :
        s_axi_araddr == pmc_pkg::OFF_IRQMASK ? {28'h0, irqMask} :
        s_axi_araddr == pmc_pkg::OFF_WAKEPIN ? 32'(wakePinEn) :
        32'h0000_0000;

    // AXI4-Lite read channel; arready is held low while data waits
    wire next_rvalid = doRead || (s_axi_rvalid && !s_axi_rready);
    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_arready <= 1'b1;
        end else begin
            s_axi_rvalid <= next_rvalid;
            s_axi_arready <= !next_rvalid;
            // Data is captured once and stands until taken
            if (doRead)
                s_axi_rdata <= rdMux;
        end
    end
    // Reads always succeed; unused offsets read as zero
    assign s_axi_rresp = 2'h0;
endmodule

/* File: testbench/pmc_props.sv */
// Port checker for the power mode controller
`timescale 1ns/1ps
module pmc_props #(
    parameter int NPIO = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Bus handshake
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Power and pins
    input wire logic resetPin_n,
    input wire logic [NPIO-1:0] pioOut,
    input wire logic [NPIO-1:0] pinOut,
    input wire logic pioLatched,
    input wire pmc_pkg::gates_s gates,
    input wire logic cpuReset,
    input wire logic porEnable
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Responses stand until taken
    chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && s_axi_bresp == 2'h0) else $error("bvalid lost");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
    // No new request while an answer waits
    chk_write_block: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready) else $error("write not blocked");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid ##0 !s_axi_arready) else $error("read late");
    // Held core never gets its clock
    chk_held_gated: assert property (cpuReset |-> !gates.cpu)
        else $error("cpu clocked in reset");
    // Latched pins hold, free pins follow one cycle later
    chk_pin_frozen: assert property (pioLatched && $past(pioLatched)
        && $past(nrst) |-> $stable(pinOut)) else $error("latched pin moved");
    chk_pin_follow: assert property (!pioLatched && !$past(pioLatched)
        && $past(nrst) |-> pinOut == $past(pioOut)) else $error("pin lag");
    chk_pin_reset: assert property (!resetPin_n [*3]
        |-> ##[0:3] cpuReset) else $error("reset pin ignored");
    chk_por_on: assert property (!cpuReset |-> porEnable)
        else $error("por detector off");
    // Main scenarios
    cov_write: cover property (s_axi_bvalid && s_axi_bready);
    cov_read: cover property (s_axi_rvalid && s_axi_rready);
    cov_latch: cover property ($rose(pioLatched));
    cov_wake: cover property ($rose(gates.cpu));
endmodule
bind power_mode_controller pmc_props #(.NPIO(NPIO)) i_props (
    .clk, .nrst, .s_axi_awready, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .resetPin_n, .pioOut,
    .pinOut, .pioLatched, .gates, .cpuReset, .porEnable
);

/* File: testbench/test_power_mode_controller.sv */
// Register-level testbench for the power mode controller
`timescale 1ns/1ps
module test_power_mode_controller;
    localparam int NPIO = 8;
    // Short cold boot keeps the run brief
    localparam int COLD = 20;
    // Driven inputs
    logic clk = 0, nrst = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic irqEvent = 0, rtcEvent = 0, sensorEvent = 0, resetPin_n = 1;
    logic slowClkIn = 0;
    logic [NPIO-1:0] pinIn = 8'h00, pioOut = 8'h00;
    // Observed outputs
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, pioLatched, clkOutPin, alwaysOnPower, sensorPower;
    logic cpuReset, bodEnable, porEnable, fastRcSel, slowRcSel, pllDouble;
    logic irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, d;
    logic [NPIO-1:0] pinOut;
    pmc_pkg::gates_s gates;
    int failures = 0, samples_checked = 0, n;

    power_mode_controller #(.NPIO(NPIO), .WAKE_COLD(COLD), .BOD_PERIOD(16))
    i_dut (.clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .irqEvent, .rtcEvent, .sensorEvent,
        .resetPin_n, .pinIn, .slowClkIn, .pioOut, .pinOut, .pioLatched,
        .clkOutPin, .gates, .alwaysOnPower, .sensorPower, .cpuReset,
        .bodEnable, .porEnable, .fastRcSel, .slowRcSel, .pllDouble, .irq);

    // 20 MHz clock
    initial begin
        forever #25 clk = ~clk;
    end

    // Verdict and end of run
    task automatic complete_run();
        $display("failures=%0d samples_checked=%0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic checkWord(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic checkBit(input logic got, input logic exp);
        checkWord({31'h0, got}, {31'h0, exp});
    endtask

    // Address and data offered together, each released when taken
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] v);
        bit aw, w;
        @(posedge clk);
        aw = 1;
        w = 1;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (aw || w) begin
            @(posedge clk);
            if (aw && s_axi_awready) begin
                aw = 0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready) begin
                w = 0;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask

    task automatic axiRead(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (s_axi_rvalid !== 1'b1);
        v = s_axi_rdata;
        s_axi_rready <= 1'b0;
    endtask

    // Cycles until the core clock runs again
    task automatic waitCpu(output int c);
        c = 0;
        while (gates.cpu !== 1'b1) begin
            @(posedge clk);
            c++;
        end
    endtask

    // Hang guard, well beyond the longest wake-up
    initial begin
        repeat (30000) @(posedge clk);
        failures++;
        complete_run();
    end

    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        waitCpu(n);
        checkBit(gates.periph, 1'b1);
        checkBit(pllDouble, 1'b1);
        checkBit(slowRcSel, 1'b1);
        checkBit(bodEnable, 1'b1);
        axiRead(pmc_pkg::OFF_CLKSEL, d);
        checkWord(d, {28'h0, pmc_pkg::CLKSEL_RST});
        axiRead(pmc_pkg::OFF_RSTCAUSE, d);
        checkWord(d, {30'h0, pmc_pkg::CAUSE_POR});
        axiRead(8'h1C, d);
        checkWord({30'h0, s_axi_rresp}, 32'h0000_0000);
        checkWord(d, 32'h0000_0000);
        axiRead(pmc_pkg::OFF_IRQSTAT, d);
        checkWord(d & 32'h0000_0008, 32'h0000_0008);
        axiRead(pmc_pkg::OFF_IRQSTAT, d);
        checkWord(d & 32'h0000_0008, 32'h0000_0000);
        // Alternate clock sources and clock-out pin
        axiWrite(pmc_pkg::OFF_CLKSEL, 32'h0000_0007);
        slowClkIn <= 1'b1;
        repeat (5) @(posedge clk);
        checkBit(clkOutPin, 1'b1);
        checkBit(fastRcSel, 1'b1);
        checkBit(slowRcSel, 1'b0);
        slowClkIn <= 1'b0;
        repeat (5) @(posedge clk);
        checkBit(clkOutPin, 1'b0);
        // Idle with the sleep event masked, then unmasked
        axiWrite(pmc_pkg::OFF_MODE, {30'h0, pmc_pkg::REQ_IDLE});
        while (gates.cpu !== 1'b0) @(posedge clk);
        repeat (4) @(posedge clk);
        checkBit(gates.mem, 1'b0);
        checkBit(gates.periph, 1'b1);
        checkBit(irq, 1'b0);
        axiWrite(pmc_pkg::OFF_IRQMASK, 32'h0000_0002);
        repeat (3) @(posedge clk);
        checkBit(irq, 1'b1);
        irqEvent <= 1'b1;
        waitCpu(n);
        irqEvent <= 1'b0;
        checkBit(n >= pmc_pkg::WAKE_IDLE_CYC, 1'b1);
        checkBit(n <= pmc_pkg::WAKE_IDLE_CYC + 10, 1'b1);
        axiRead(pmc_pkg::OFF_IRQSTAT, d);
        checkWord(d & 32'h0000_0003, 32'h0000_0003);
        repeat (3) @(posedge clk);
        checkBit(irq, 1'b0);
        // Standby: pins freeze, an interrupt does not wake
        pioOut <= 8'hA5;
        axiWrite(pmc_pkg::OFF_MODE, {30'h0, pmc_pkg::REQ_STBY});
        while (pioLatched !== 1'b1) @(posedge clk);
        pioOut <= 8'h5A;
        irqEvent <= 1'b1;
        repeat (400) @(posedge clk);
        irqEvent <= 1'b0;
        checkWord(32'(pinOut), 32'h0000_00A5);
        checkBit(gates.cpu, 1'b0);
        rtcEvent <= 1'b1;
        waitCpu(n);
        rtcEvent <= 1'b0;
        checkBit(n >= pmc_pkg::WAKE_STBY_CYC, 1'b1);
        checkBit(n <= pmc_pkg::WAKE_STBY_CYC + 10, 1'b1);
        repeat (4) @(posedge clk);
        checkWord(32'(pinOut), 32'h0000_005A);
        axiRead(pmc_pkg::OFF_CLKSEL, d);
        checkWord(d, 32'h0000_0007);
        // Standby again, woken by the sensor controller
        axiWrite(pmc_pkg::OFF_MODE, {30'h0, pmc_pkg::REQ_STBY});
        while (pioLatched !== 1'b1) @(posedge clk);
        sensorEvent <= 1'b1;
        waitCpu(n);
        sensorEvent <= 1'b0;
        checkBit(n >= pmc_pkg::WAKE_STBY_CYC, 1'b1);
        checkBit(n <= pmc_pkg::WAKE_STBY_CYC + 10, 1'b1);
        // Shutdown, woken by an enabled pin as a reset
        axiWrite(pmc_pkg::OFF_WAKEPIN, 32'h0000_0001);
        axiWrite(pmc_pkg::OFF_MODE, {30'h0, pmc_pkg::REQ_SHUT});
        while (alwaysOnPower !== 1'b0) @(posedge clk);
        pioOut <= 8'hFF;
        repeat (4) @(posedge clk);
        checkBit(sensorPower, 1'b0);
        checkBit(bodEnable, 1'b0);
        checkWord(32'(pinOut), 32'h0000_005A);
        pinIn <= 8'h01;
        waitCpu(n);
        checkBit(n <= COLD + 20, 1'b1);
        axiRead(pmc_pkg::OFF_RSTCAUSE, d);
        checkWord(d, {30'h0, pmc_pkg::CAUSE_WAKEPIN});
        axiRead(pmc_pkg::OFF_CLKSEL, d);
        checkWord(d, {28'h0, pmc_pkg::CLKSEL_RST});
        // Reset pin from active
        resetPin_n <= 1'b0;
        repeat (6) @(posedge clk);
        checkBit(cpuReset, 1'b1);
        resetPin_n <= 1'b1;
        waitCpu(n);
        axiRead(pmc_pkg::OFF_RSTCAUSE, d);
        checkWord(d, {30'h0, pmc_pkg::CAUSE_PIN});
        complete_run();
    end
endmodule
